// >>> radio_spi_defines.vh
/*
 Offsets, fields, reset values and timing counts for the radio host port.
 Assumes inclusion by bare name from design and bench files.
*/
`ifndef RADIO_SPI_DEFINES_VH
`define RADIO_SPI_DEFINES_VH

`define CMD_DIR_BIT        7
`define CMD_INC_BIT        6
`define ADDR_W             6
`define DATA_W             8

`define REG_IRQ_CONFIG     6'h05
`define REG_RX_IRQ_ENABLE  6'h07
`define REG_RX_IRQ_STATUS  6'h08
`define REG_TX_IRQ_ENABLE  6'h0D
`define REG_TX_IRQ_STATUS  6'h0E
`define REG_WAKE_IRQ_EN    6'h1C
`define REG_WAKE_IRQ_STAT  6'h1D

`define CFG_POL_BIT        0
`define WAKE_BIT           0

`define RST_IRQ_CONFIG     8'h01
`define RST_ENABLE         8'h00
`define RX_CHAN_A_MASK     8'h0F

`define OSC_START_NS       100000
`define CLK_PERIOD_NS      100
`define OSC_START_CYC      (`OSC_START_NS / `CLK_PERIOD_NS)

`endif

// >>> irq_reg_bank.v
/*
 Small register bank holding the four interrupt control bytes.
 Assumes a single writer per cycle; read data is registered.
*/
`default_nettype none
`include "radio_spi_defines.vh"

module irq_reg_bank #(
    parameter AW = 6,
    parameter DW = 8
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst_n,
    // Write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // Read port
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data_q,
    // Live values
    output reg  [DW-1:0] cfg_q,
    output reg  [DW-1:0] rx_en_q,
    output reg  [DW-1:0] tx_en_q,
    output reg  [DW-1:0] wake_en_q
);

    // Enables are kept regardless of tx/rx mode
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q     <= `RST_IRQ_CONFIG;
            rx_en_q   <= `RST_ENABLE;
            tx_en_q   <= `RST_ENABLE;
            wake_en_q <= `RST_ENABLE;
        end else if (wr_en) begin
            case (wr_addr)
                `REG_IRQ_CONFIG:    cfg_q     <= wr_data;
                `REG_RX_IRQ_ENABLE: rx_en_q   <= wr_data;
                `REG_TX_IRQ_ENABLE: tx_en_q   <= wr_data;
                `REG_WAKE_IRQ_EN:   wake_en_q <= wr_data;
                default: begin
                end
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= {DW{1'b0}};
        end else begin
            case (rd_addr)
                `REG_IRQ_CONFIG:    rd_data_q <= cfg_q;
                `REG_RX_IRQ_ENABLE: rd_data_q <= rx_en_q;
                `REG_TX_IRQ_ENABLE: rd_data_q <= tx_en_q;
                `REG_WAKE_IRQ_EN:   rd_data_q <= wake_en_q;
                default:            rd_data_q <= {DW{1'b0}};
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> radio_spi_host_port_irq.v
/*
 SPI slave host port with interrupt aggregation and bit-serial bypass.
 Assumes SPI pins and power-down are asynchronous to clk; clk is much
 faster than sck. Event inputs come from logic on clk.
*/
`default_nettype none
`include "radio_spi_defines.vh"

module radio_spi_host_port_irq #(
    parameter OSC_START_CYCLES = `OSC_START_CYC
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // SPI pins
    input  wire       sck,
    input  wire       mosi,
    input  wire       ss_n,
    output reg        miso_q,
    output reg        miso_oe_q,
    // Request pin, open drain or open source
    input  wire       irq_in,
    output reg        irq_out_q,
    output reg        irq_oe_q,
    // Power-down pin, active low
    input  wire       power_down_pin_n,
    output reg        osc_run_q,
    // Modem mode
    input  wire       tx_mode,
    input  wire       rx_mode,
    input  wire       single_chan_mode,
    input  wire       bypass_mode,
    // Events from the byte serializers
    input  wire [3:0] tx_event,
    input  wire [7:0] rx_event,
    // Bypass bit path
    input  wire       rx_bit,
    input  wire       rx_bit_valid,
    output reg        bypass_serial_data_q,
    output reg        bypass_data_qualifier_q,
    output reg        bypass_data_oe_q,
    input  wire       bypass_serial_data_in,
    input  wire       bypass_data_qualifier_in,
    output reg        tx_bit_q,
    output reg        tx_bit_valid_q,
    output reg        tx_bit_stb_q
);

    // Two-stage synchronisers for all pins
    // Select resets high and sck low, so no false edge follows reset
    reg [1:0] sck_s_q;
    reg [1:0] mosi_s_q;
    reg [1:0] ss_s_q;
    reg [1:0] irq_s_q;
    reg [1:0] pd_s_q;
    reg [1:0] bd_s_q;
    reg [1:0] bq_s_q;
    reg       sck_d1_q;
    reg       irq_d1_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_s_q  <= 2'h0;
            mosi_s_q <= 2'h0;
            ss_s_q   <= 2'h3;
            irq_s_q  <= 2'h0;
            pd_s_q   <= 2'h0;
            bd_s_q   <= 2'h0;
            bq_s_q   <= 2'h0;
            sck_d1_q <= 1'b0;
            irq_d1_q <= 1'b0;
        end else begin
            sck_s_q  <= {sck_s_q[0], sck};
            mosi_s_q <= {mosi_s_q[0], mosi};
            ss_s_q   <= {ss_s_q[0], ss_n};
            irq_s_q  <= {irq_s_q[0], irq_in};
            pd_s_q   <= {pd_s_q[0], power_down_pin_n};
            bd_s_q   <= {bd_s_q[0], bypass_serial_data_in};
            bq_s_q   <= {bq_s_q[0], bypass_data_qualifier_in};
            sck_d1_q <= sck_s_q[1];
            irq_d1_q <= irq_s_q[1];
        end
    end

    wire sck_rise = sck_s_q[1] & ~sck_d1_q;
    wire sck_fall = ~sck_s_q[1] & sck_d1_q;
    wire selected = ~ss_s_q[1];
    wire irq_fall = ~irq_s_q[1] & irq_d1_q;

    // SPI transaction engine
    localparam ST_CMD  = 2'b00;
    localparam ST_DATA = 2'b01;
    localparam ST_IDLE = 2'b10;

    reg  [1:0] state_q;
    reg  [2:0] bit_cnt_q;
    reg  [7:0] shift_in_q;
    reg  [7:0] shift_out_q;
    reg        dir_wr_q;
    reg        inc_q;
    reg  [5:0] addr_q;
    reg        wr_en_q;
    reg  [5:0] wr_addr_q;
    reg  [7:0] wr_data_q;
    reg        rd_stat_q;
    reg        load_pend_q;
    reg        load_wait_q;
    wire [7:0] bank_rd;
    wire [7:0] cfg;
    wire [7:0] rx_en;
    wire [7:0] tx_en;
    wire [7:0] wake_en;
    wire [7:0] byte_in = {shift_in_q[6:0], mosi_s_q[1]};
    reg  [7:0] rx_stat_q;
    reg  [7:0] tx_stat_q;
    reg        wake_stat_q;
    reg  [7:0] rd_word;

    // Status registers are not in the bank, muxed here
    always @* begin
        case (addr_q)
            `REG_RX_IRQ_STATUS: rd_word = rx_stat_q;
            `REG_TX_IRQ_STATUS: rd_word = tx_stat_q;
            `REG_WAKE_IRQ_STAT: rd_word = {7'h00, wake_stat_q};
            default:            rd_word = bank_rd;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= ST_IDLE;
            bit_cnt_q   <= 3'h0;
            shift_in_q  <= 8'h00;
            shift_out_q <= 8'h00;
            dir_wr_q    <= 1'b0;
            inc_q       <= 1'b0;
            addr_q      <= 6'h00;
            wr_en_q     <= 1'b0;
            wr_addr_q   <= 6'h00;
            wr_data_q   <= 8'h00;
            rd_stat_q   <= 1'b0;
            load_pend_q <= 1'b0;
            load_wait_q <= 1'b0;
            miso_q      <= 1'b0;
            miso_oe_q   <= 1'b0;
        end else begin
            wr_en_q   <= 1'b0;
            rd_stat_q <= 1'b0;
            if (!selected) begin
                state_q     <= ST_IDLE;
                bit_cnt_q   <= 3'h0;
                load_pend_q <= 1'b0;
                load_wait_q <= 1'b0;
                miso_oe_q   <= 1'b0;
            end else begin
                if (state_q == ST_IDLE) begin
                    state_q <= ST_CMD;
                end
                if (load_pend_q) begin
                    // Bank read port needs a cycle for the new address
                    load_pend_q <= 1'b0;
                    load_wait_q <= 1'b1;
                end
                if (load_wait_q) begin
                    // Lands after the master's last sample of the byte
                    load_wait_q <= 1'b0;
                    shift_out_q <= rd_word;
                    miso_q      <= rd_word[7];
                    miso_oe_q   <= 1'b1;
                    if (addr_q == `REG_WAKE_IRQ_STAT) begin
                        rd_stat_q <= 1'b1;
                    end
                end
                if (sck_rise) begin
                    shift_in_q <= byte_in;
                    bit_cnt_q  <= bit_cnt_q + 3'h1;
                    if (bit_cnt_q == 3'h7) begin
                        case (state_q)
                            ST_CMD, ST_IDLE: begin
                                state_q  <= ST_DATA;
                                dir_wr_q <= byte_in[`CMD_DIR_BIT];
                                inc_q    <= byte_in[`CMD_INC_BIT];
                                addr_q   <= byte_in[5:0];
                                load_pend_q <= ~byte_in[`CMD_DIR_BIT];
                            end
                            ST_DATA: begin
                                if (dir_wr_q) begin
                                    wr_en_q   <= 1'b1;
                                    wr_addr_q <= addr_q;
                                    wr_data_q <= byte_in;
                                end
                                if (inc_q) begin
                                    addr_q <= addr_q + 6'h01;
                                end
                                load_pend_q <= ~dir_wr_q;
                            end
                            default: state_q <= ST_IDLE;
                        endcase
                    end
                end
                if (sck_fall && state_q == ST_DATA && !dir_wr_q
                        && bit_cnt_q != 3'h0) begin
                    // Launch next bit on falling edge
                    shift_out_q <= {shift_out_q[6:0], 1'b0};
                    miso_q      <= shift_out_q[6];
                end
            end
        end
    end

    irq_reg_bank #(
        .AW(`ADDR_W),
        .DW(`DATA_W)
    ) u_bank (
        .clk       (clk),
        .rst_n     (rst_n),
        .wr_en     (wr_en_q),
        .wr_addr   (wr_addr_q),
        .wr_data   (wr_data_q),
        .rd_addr   (addr_q),
        .rd_data_q (bank_rd),
        .cfg_q     (cfg),
        .rx_en_q   (rx_en),
        .tx_en_q   (tx_en),
        .wake_en_q (wake_en)
    );

    // Oscillator start timer after power-down release
    // Restarts on every power-down, so wake is raised again each time
    reg [31:0] osc_cnt_q;
    reg        wake_set;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_q <= 32'h0;
            osc_run_q <= 1'b0;
        end else if (!pd_s_q[1]) begin
            osc_cnt_q <= 32'h0;
            osc_run_q <= 1'b0;
        end else if (!osc_run_q) begin
            if (osc_cnt_q >= OSC_START_CYCLES - 1) begin
                osc_run_q <= 1'b1;
            end else begin
                osc_cnt_q <= osc_cnt_q + 32'h1;
            end
        end
    end

    always @* begin
        wake_set = pd_s_q[1] && !osc_run_q
                   && osc_cnt_q >= OSC_START_CYCLES - 1;
    end

    // Wake status sticky, set wins over read-clear; rx and tx status follow events
    wire [7:0] rx_evt_ok = single_chan_mode ?
                           (rx_event & `RX_CHAN_A_MASK) : rx_event;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_stat_q   <= 8'h00;
            tx_stat_q   <= 8'h00;
            wake_stat_q <= 1'b0;
        end else begin
            // Events latched regardless of enable
            rx_stat_q <= rx_evt_ok;
            tx_stat_q <= {4'h0, tx_event};
            if (wake_set) begin
                wake_stat_q <= 1'b1;
            end else if (rd_stat_q) begin
                wake_stat_q <= 1'b0;
            end
        end
    end

    // Request aggregation with mode gating
    wire rx_act = |(rx_stat_q & rx_en) & ~tx_mode;
    wire tx_act = |(tx_stat_q & tx_en) & ~rx_mode;
    wire wk_act = wake_stat_q & wake_en[`WAKE_BIT];
    wire pol_hi = cfg[`CFG_POL_BIT];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_q <= 1'b0;
            irq_oe_q  <= 1'b0;
        end else if (bypass_mode) begin
            // Pin becomes a bit clock owned by the host
            irq_out_q <= 1'b0;
            irq_oe_q  <= 1'b0;
        end else begin
            irq_out_q <= pol_hi;
            irq_oe_q  <= rx_act | tx_act | wk_act;
        end
    end

    // Bypass bit path clocked by request-pin falling edges
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bypass_serial_data_q    <= 1'b0;
            bypass_data_qualifier_q <= 1'b0;
            bypass_data_oe_q        <= 1'b0;
            tx_bit_q                <= 1'b0;
            tx_bit_valid_q          <= 1'b0;
            tx_bit_stb_q            <= 1'b0;
        end else begin
            tx_bit_stb_q     <= 1'b0;
            bypass_data_oe_q <= bypass_mode & rx_mode;
            if (bypass_mode && irq_fall) begin
                if (rx_mode) begin
                    // Stable for the host's rising edge
                    bypass_serial_data_q    <= rx_bit;
                    bypass_data_qualifier_q <= rx_bit_valid;
                end else if (tx_mode) begin
                    tx_bit_q       <= bd_s_q[1];
                    tx_bit_valid_q <= bq_s_q[1];
                    tx_bit_stb_q   <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> spi_master_model.sv
/*
 SPI master model standing in for the host microcontroller.
 Assumes the bench calls its tasks from clk falling edges.
*/
`default_nettype none
module spi_master_model (
    // Timing reference
    input  wire logic clk,
    // SPI link
    output var  logic sck,
    output var  logic mosi,
    output var  logic ss_n,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sck  = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
    end
    // Four clk per half period gives the 800 ns link period
    task automatic half();
        repeat (4) @(negedge clk);
    endtask
    task automatic sel();
        @(negedge clk);
        ss_n = 1'b0;
        half();
    endtask
    task automatic desel();
        half();
        ss_n = 1'b1;
        mosi = ~mosi; // Released line never keeps the last bit
        half();
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            half();
            sck = 1'b1;
            half();
            rx[i] = miso; // Sampled late in the high phase, still stable
            sck = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> radio_spi_host_port_irq_properties.sv
/*
 Port checker for the radio host port.
 Assumes it is bound to the top module and sees only its ports.
*/
`default_nettype none
module radio_spi_host_port_irq_properties #(
    parameter int OSC_START_CYCLES = 1000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins and modes
    input wire logic ss_n,
    input wire logic miso_oe_q,
    input wire logic irq_oe_q,
    input wire logic power_down_pin_n,
    input wire logic osc_run_q,
    input wire logic rx_mode,
    input wire logic bypass_mode,
    input wire logic bypass_data_oe_q,
    input wire logic tx_bit_stb_q
);
    timeunit 1ns;
    timeprecision 1ns;
    int hi_cnt;
    // Cycles since power-down release, saturating
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt <= 0;
        end else if (!power_down_pin_n) begin
            hi_cnt <= 0;
        end else if (hi_cnt < OSC_START_CYCLES + 8) begin
            hi_cnt <= hi_cnt + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    miso_release_a: assert property (
        ss_n [*6] |-> !miso_oe_q) else $error("miso driven deselected");
    oe_select_a: assert property (
        $rose(miso_oe_q) |-> !ss_n && !$past(ss_n, 8))
        else $error("miso enabled without a command");
    oe_end_a: assert property (
        $fell(miso_oe_q) |-> ss_n && $past(ss_n, 2))
        else $error("miso released inside a burst");
    byp_irq_a: assert property (
        bypass_mode [*3] |-> !irq_oe_q) else $error("request in bypass");
    byp_oe_a: assert property (
        (!(bypass_mode && rx_mode)) [*3] |-> !bypass_data_oe_q)
        else $error("bypass data driven outside receive");
    stb_pulse_a: assert property (
        tx_bit_stb_q |=> !tx_bit_stb_q) else $error("strobe too long");
    stb_bypass_a: assert property (
        tx_bit_stb_q |-> bypass_mode) else $error("strobe outside bypass");
    osc_down_a: assert property (
        !power_down_pin_n [*4] |-> !osc_run_q) else $error("osc in pd");
    osc_start_a: assert property (
        $rose(osc_run_q) |-> hi_cnt >= OSC_START_CYCLES - 1
            && hi_cnt <= OSC_START_CYCLES + 5)
        else $error("oscillator ready at wrong time");
    cover property ($rose(miso_oe_q));
    cover property ($rose(irq_oe_q));
    cover property (tx_bit_stb_q);
endmodule
bind radio_spi_host_port_irq radio_spi_host_port_irq_properties #(
    .OSC_START_CYCLES(OSC_START_CYCLES)
) u_chk (.clk(clk), .rst_n(rst_n), .ss_n(ss_n), .miso_oe_q(miso_oe_q),
    .irq_oe_q(irq_oe_q), .power_down_pin_n(power_down_pin_n),
    .osc_run_q(osc_run_q), .rx_mode(rx_mode), .bypass_mode(bypass_mode),
    .bypass_data_oe_q(bypass_data_oe_q), .tx_bit_stb_q(tx_bit_stb_q));
`default_nettype wire

// >>> tb_radio_spi_host_port_irq.sv
/*
 Testbench for the radio host port: SPI registers, request pin, wake-up
 and bypass bits. Assumes the defines header and master model exist.
*/
`default_nettype none
`include "radio_spi_defines.vh"
module tb_radio_spi_host_port_irq;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OSC_CYC = 10; // Short start-up keeps the run brief
    logic       clk, rst_n, sck, mosi, ss_n, miso_q, miso_oe_q, miso_w;
    logic       irq_w, irq_drv, irq_out_q, irq_oe_q, pd_n, osc_run_q;
    logic       tx_mode, rx_mode, single_chan_mode, bypass_mode;
    logic       rx_bit, rx_bit_valid, bsd_q, bdq_q, bd_oe_q, bsd_w, bdq_w;
    logic       bsd_drv, bdq_drv, tx_bit_q, tx_bit_valid_q, tx_bit_stb_q;
    logic       miso_last = 1'b0;
    logic [3:0] tx_event, stb_n = 4'h0;
    logic [7:0] rx_event, rd;
    logic [5:0] rst_a [5] = '{`REG_RX_IRQ_ENABLE, `REG_RX_IRQ_STATUS,
        `REG_TX_IRQ_ENABLE, `REG_TX_IRQ_STATUS, `REG_WAKE_IRQ_EN};
    int         fail_count = 0, check_count = 0, cyc = 0;
    // Undriven pins show the inverse or the bench's own level
    assign miso_w = miso_oe_q ? miso_q : ~miso_last;
    assign irq_w  = irq_oe_q ? irq_out_q : irq_drv;
    assign bsd_w  = bd_oe_q ? bsd_q : bsd_drv;
    assign bdq_w  = bd_oe_q ? bdq_q : bdq_drv;
    radio_spi_host_port_irq #(.OSC_START_CYCLES(OSC_CYC)) dut (
        .clk(clk), .rst_n(rst_n), .sck(sck), .mosi(mosi), .ss_n(ss_n),
        .miso_q(miso_q), .miso_oe_q(miso_oe_q), .irq_in(irq_w),
        .irq_out_q(irq_out_q), .irq_oe_q(irq_oe_q),
        .power_down_pin_n(pd_n), .osc_run_q(osc_run_q),
        .tx_mode(tx_mode), .rx_mode(rx_mode),
        .single_chan_mode(single_chan_mode), .bypass_mode(bypass_mode),
        .tx_event(tx_event), .rx_event(rx_event), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .bypass_serial_data_q(bsd_q),
        .bypass_data_qualifier_q(bdq_q), .bypass_data_oe_q(bd_oe_q),
        .bypass_serial_data_in(bsd_w), .bypass_data_qualifier_in(bdq_w),
        .tx_bit_q(tx_bit_q), .tx_bit_valid_q(tx_bit_valid_q),
        .tx_bit_stb_q(tx_bit_stb_q));
    spi_master_model m (.clk(clk), .sck(sck), .mosi(mosi), .ss_n(ss_n),
        .miso(miso_w));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (miso_oe_q === 1'b1) miso_last <= miso_q;
        if (tx_bit_stb_q === 1'b1) stb_n <= stb_n + 4'h1;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Writes send data; reads compare each byte with the queue
    task automatic xact(input logic [7:0] cmd, input logic [7:0] q [$]);
        m.sel();
        m.xfer(cmd, rd);
        foreach (q[i]) begin
            m.xfer(cmd[7] ? q[i] : 8'h00, rd);
            if (!cmd[7]) chk(rd, q[i]);
        end
        m.desel();
    endtask
    task automatic wait_osc();
        for (int i = 0; i < 40 && osc_run_q !== 1'b1; i++) @(negedge clk);
        chk({7'h00, osc_run_q}, 8'h01);
    endtask
    task automatic tick();
        @(negedge clk) irq_drv = 1'b0;
        repeat (6) @(negedge clk);
        irq_drv = 1'b1;
        repeat (6) @(negedge clk);
    endtask
    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        {pd_n, irq_drv, bsd_drv, bdq_drv} = 4'hF;
        {tx_mode, rx_mode, single_chan_mode, bypass_mode} = 4'h0;
        {rx_bit, rx_bit_valid, tx_event, rx_event} = 14'h0000;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        wait_osc();
        xact({2'b00, `REG_WAKE_IRQ_STAT}, '{8'h01, 8'h00});
        xact({2'b00, `REG_IRQ_CONFIG}, '{`RST_IRQ_CONFIG});
        foreach (rst_a[i]) xact({2'b00, rst_a[i]}, '{8'h00});
        done("reset");
        tx_event = 4'h5;
        xact({2'b11, `REG_TX_IRQ_ENABLE}, '{8'h0F, 8'hAA});
        xact({2'b01, `REG_TX_IRQ_ENABLE}, '{8'h0F, 8'h05, 8'h00});
        xact({2'b10, `REG_RX_IRQ_ENABLE}, '{8'h0F, 8'hF0});
        xact({2'b00, `REG_RX_IRQ_ENABLE}, '{8'hF0, 8'hF0});
        done("burst");
        rx_mode = 1'b1;
        repeat (4) @(negedge clk);
        chk({7'h00, irq_oe_q}, 8'h00);
        {tx_mode, rx_mode} = 2'b10;
        repeat (4) @(negedge clk);
        chk({6'h00, irq_oe_q, irq_out_q}, 8'h03);
        xact({2'b10, `REG_IRQ_CONFIG}, '{8'h00});
        chk({6'h00, irq_oe_q, irq_out_q}, 8'h02);
        xact({2'b10, `REG_IRQ_CONFIG}, '{8'h01});
        {tx_mode, rx_mode, tx_event, rx_event} = {2'b01, 4'h0, 8'h80};
        repeat (4) @(negedge clk);
        chk({6'h00, irq_oe_q, irq_out_q}, 8'h03);
        single_chan_mode = 1'b1;
        repeat (4) @(negedge clk);
        chk({7'h00, irq_oe_q}, 8'h00);
        xact({2'b00, `REG_RX_IRQ_STATUS}, '{8'h00});
        single_chan_mode = 1'b0;
        xact({2'b10, `REG_RX_IRQ_ENABLE}, '{8'h00});
        chk({7'h00, irq_oe_q}, 8'h00);
        xact({2'b00, `REG_RX_IRQ_STATUS}, '{8'h80});
        xact({2'b00, `REG_TX_IRQ_ENABLE}, '{8'h0F});
        rx_event = 8'h00;
        done("request");
        xact({2'b10, `REG_WAKE_IRQ_EN}, '{8'h01});
        rx_mode = 1'b0;
        pd_n = 1'b0;
        repeat (8) @(negedge clk);
        chk({7'h00, osc_run_q}, 8'h00);
        pd_n = 1'b1;
        wait_osc();
        repeat (4) @(negedge clk);
        chk({7'h00, irq_oe_q}, 8'h01);
        xact({2'b00, `REG_WAKE_IRQ_STAT}, '{8'h01});
        chk({7'h00, irq_oe_q}, 8'h00);
        done("wake");
        {bypass_mode, rx_mode, rx_bit, rx_bit_valid} = 4'hF;
        tick();
        chk({5'h00, bd_oe_q, bsd_w, bdq_w}, 8'h07);
        rx_bit = 1'b0;
        tick();
        chk({5'h00, bd_oe_q, bsd_w, bdq_w}, 8'h05);
        {rx_mode, tx_mode, bsd_drv, bdq_drv} = 4'h6;
        tick();
        chk({stb_n, 2'b00, tx_bit_q, tx_bit_valid_q}, 8'h12);
        {bsd_drv, bdq_drv} = 2'b01;
        tick();
        chk({stb_n, 2'b00, tx_bit_q, tx_bit_valid_q}, 8'h21);
        done("bypass");
        close_out();
    end
endmodule
`default_nettype wire
